// >>> inc/evt_pkg.sv
// Shared constants for the event-flag block and its firmware-side end.
// Assumes a single 200 MHz system clock and synchronous active-high reset.
package evt_pkg;
  localparam int unsigned PTR_W        = 13;
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned FILT_W       = 8;
  // Filter control bit positions
  localparam int unsigned FILT_CRC_BIT  = 5;
  localparam int unsigned FILT_WAKE_BIT = 3;
  // Transmit status vector length in bytes
  localparam int unsigned TX_STATUS_LEN = 7;
  // PHY start-up time
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned PHY_START_US   = 1000;
  localparam int unsigned PHY_START_CYC  = PHY_START_US * CLK_MHZ;
  localparam logic [PTR_W-1:0] RING_START_RST = 13'h0000;
  localparam logic [PTR_W-1:0] RING_END_RST   = 13'h1FFF;
  localparam logic [CNT_W-1:0] CNT_MAX        = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 8'h00;
endpackage

// >>> inc/evt_if.sv
// Interface joining the event-flag device end and the firmware end.
// Assumes both ends share clk_sys; no clocking block.
`timescale 1ns/100ps
interface evt_if;
  import evt_pkg::*;
  logic             tx_request_set;
  logic             tx_request_cancel;
  logic             tx_request;
  logic             tx_abort_status;
  logic             copy_start_set;
  logic             copy_start_cancel;
  logic             copy_start;
  logic             tx_done_irq_en;
  logic             copy_done_irq_en;
  logic             link_change_irq_en;
  logic             rx_pending_irq_en;
  logic             module_irq_en;
  logic             phy_link_irq_en;
  logic             phy_global_irq_en;
  logic             tx_done_clr;
  logic             copy_done_clr;
  logic             phy_irq_request_rd;
  logic             rx_count_dec;
  logic [FILT_W-1:0] rx_filter_ctrl;
  logic             ring_start_wr;
  logic             ring_end_wr;
  logic [PTR_W-1:0] ring_wdata;
  logic             rd_ptr_low_wr;
  logic             rd_ptr_high_wr;
  logic [7:0]       rd_ptr_byte;
  logic             tx_done_flag;
  logic             link_change_flag;
  logic             phy_global_flag;
  logic             phy_link_flag;
  logic             copy_done_flag;
  logic             rx_pending_flag;
  logic [CNT_W-1:0] rx_packet_count;
  logic [PTR_W-1:0] rx_ring_start;
  logic [PTR_W-1:0] rx_ring_end;
  logic [PTR_W-1:0] rx_write_ptr;
  logic [PTR_W-1:0] rx_read_ptr;
  logic             module_irq;
  logic             phy_ready;

  modport dev (
    input  tx_request_set, tx_request_cancel, copy_start_set, copy_start_cancel,
    input  tx_done_irq_en, copy_done_irq_en, link_change_irq_en, rx_pending_irq_en,
    input  module_irq_en, phy_link_irq_en, phy_global_irq_en,
    input  tx_done_clr, copy_done_clr, phy_irq_request_rd, rx_count_dec,
    input  rx_filter_ctrl, ring_start_wr, ring_end_wr, ring_wdata,
    input  rd_ptr_low_wr, rd_ptr_high_wr, rd_ptr_byte,
    output tx_request, tx_abort_status, copy_start,
    output tx_done_flag, link_change_flag, phy_global_flag, phy_link_flag,
    output copy_done_flag, rx_pending_flag, rx_packet_count,
    output rx_ring_start, rx_ring_end, rx_write_ptr, rx_read_ptr, module_irq, phy_ready
  );
  modport fw (
    output tx_request_set, tx_request_cancel, copy_start_set, copy_start_cancel,
    output tx_done_irq_en, copy_done_irq_en, link_change_irq_en, rx_pending_irq_en,
    output module_irq_en, phy_link_irq_en, phy_global_irq_en,
    output tx_done_clr, copy_done_clr, phy_irq_request_rd, rx_count_dec,
    output rx_filter_ctrl, ring_start_wr, ring_end_wr, ring_wdata,
    output rd_ptr_low_wr, rd_ptr_high_wr, rd_ptr_byte,
    input  tx_request, tx_abort_status, copy_start,
    input  tx_done_flag, link_change_flag, phy_global_flag, phy_link_flag,
    input  copy_done_flag, rx_pending_flag, rx_packet_count,
    input  rx_ring_start, rx_ring_end, rx_write_ptr, rx_read_ptr, module_irq, phy_ready
  );
endinterface

// >>> verilog/evt_dev.sv
// Device end: event flags, gated interrupt request and receive ring pointers.
// Assumes transmit, copy, PHY and receive engines report through plain pulses.
`timescale 1ns/100ps
module evt_dev
  import evt_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  evt_if.dev                    bus,
  input  wire logic             tx_end,
  input  wire logic             tx_abort,
  input  wire logic             copy_end,
  input  wire logic             link_status_change,
  input  wire logic             rx_packet_stored,
  input  wire logic             rx_wake_frame,
  input  wire logic             rx_wr_advance,
  input  wire logic             module_power_en,
  output logic [PTR_W-1:0]      tx_status_addr,
  output logic                  rx_addr_in_ring
);
  typedef struct packed {
    logic             tx_req;
    logic             tx_abort;
    logic             copy_st;
    logic             tx_done;
    logic             copy_done;
    logic             phy_link;
    logic             phy_global;
    logic             link_change;
    logic [CNT_W-1:0] pkt_cnt;
    logic [PTR_W-1:0] ring_start;
    logic [PTR_W-1:0] ring_end;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [7:0]       rd_low_hold;
    logic             irq;
    logic [17:0]      phy_cnt;
    logic             phy_rdy;
    logic             rx_pend;
    logic             in_ring;
  } state_t;

  state_t      st_r;
  state_t      st_nxt;
  logic        phy_en;
  logic        wake_ok;
  logic        new_pkt;
  logic        tx_cause;
  logic        link_cause;
  logic        copy_cause;
  logic        rx_cause;
  logic [17:0] phy_done_cnt;

  assign phy_en  = bus.phy_link_irq_en & bus.phy_global_irq_en;
  assign wake_ok = bus.rx_filter_ctrl[FILT_CRC_BIT] & bus.rx_filter_ctrl[FILT_WAKE_BIT];
  assign new_pkt = (rx_packet_stored | (rx_wake_frame & wake_ok)) & (st_r.pkt_cnt != CNT_MAX);
  // Start-up count sized to the timer
  assign phy_done_cnt = 18'(PHY_START_CYC);
  // Per-source causes, each gated by its own enable
  assign tx_cause   = st_r.tx_done & bus.tx_done_irq_en;
  assign link_cause = st_r.link_change & bus.link_change_irq_en & phy_en;
  assign copy_cause = st_r.copy_done & bus.copy_done_irq_en;
  assign rx_cause   = new_pkt & bus.rx_pending_irq_en;

  always_comb begin
    st_nxt = st_r;
    // Transmit request: set by firmware, fall on end, abort or cancel
    if (bus.tx_request_set) begin
      st_nxt.tx_req = 1'b1;
    end
    if (st_r.tx_req && (tx_end || tx_abort || bus.tx_request_cancel)) begin
      st_nxt.tx_req = 1'b0;
    end
    if (st_r.tx_req && tx_abort) begin
      st_nxt.tx_abort = 1'b1;
    end else if (bus.tx_request_set) begin
      st_nxt.tx_abort = 1'b0;
    end
    if (bus.copy_start_set) begin
      st_nxt.copy_st = 1'b1;
    end
    if (st_r.copy_st && (copy_end || bus.copy_start_cancel)) begin
      st_nxt.copy_st = 1'b0;
    end
    // Sticky flags, set beats clear
    if (bus.tx_done_clr) begin
      st_nxt.tx_done = 1'b0;
    end
    if (st_r.tx_req && !st_nxt.tx_req) begin
      st_nxt.tx_done = 1'b1;
    end
    if (bus.copy_done_clr) begin
      st_nxt.copy_done = 1'b0;
    end
    if (st_r.copy_st && !st_nxt.copy_st) begin
      st_nxt.copy_done = 1'b1;
    end
    // PHY request flags: read clears, a change in the same cycle wins
    if (bus.phy_irq_request_rd) begin
      st_nxt.phy_link = 1'b0;
    end
    if (link_status_change) begin
      st_nxt.phy_link = 1'b1;
    end
    st_nxt.phy_global  = st_nxt.phy_link & phy_en;
    st_nxt.link_change = phy_en & st_nxt.phy_global;
    // Packet counter
    if (new_pkt && !(bus.rx_count_dec && st_r.pkt_cnt != CNT_ZERO)) begin
      st_nxt.pkt_cnt = st_r.pkt_cnt + 8'h01;
    end else if (!new_pkt && bus.rx_count_dec && st_r.pkt_cnt != CNT_ZERO) begin
      st_nxt.pkt_cnt = st_r.pkt_cnt - 8'h01;
    end
    // Pending flag registered with the count it decodes
    st_nxt.rx_pend = (st_nxt.pkt_cnt != CNT_ZERO);
    // Ring pointers
    if (bus.ring_start_wr) begin
      st_nxt.ring_start = bus.ring_wdata;
    end
    if (bus.ring_end_wr) begin
      st_nxt.ring_end = bus.ring_wdata;
    end
    if (bus.ring_start_wr || bus.ring_end_wr) begin
      st_nxt.wr_ptr = st_nxt.ring_start;
    end else if (rx_wr_advance) begin
      st_nxt.wr_ptr = (st_r.wr_ptr == st_r.ring_end) ? st_r.ring_start
                                                     : st_r.wr_ptr + 13'h0001;
    end
    // Ring membership registered with the pointer it tests
    st_nxt.in_ring = (st_nxt.wr_ptr >= st_nxt.ring_start)
                     && (st_nxt.wr_ptr <= st_nxt.ring_end);
    if (bus.rd_ptr_low_wr) begin
      st_nxt.rd_low_hold = bus.rd_ptr_byte;
    end
    if (bus.rd_ptr_high_wr) begin
      st_nxt.rd_ptr = {bus.rd_ptr_byte[PTR_W-9:0], st_r.rd_low_hold};
    end
    // Interrupt request, registered
    st_nxt.irq = bus.module_irq_en & (tx_cause | link_cause | copy_cause | rx_cause);
    // PHY start-up timer
    if (!module_power_en) begin
      st_nxt.phy_cnt = 18'h00000;
      st_nxt.phy_rdy = 1'b0;
    end else if (st_r.phy_cnt == phy_done_cnt) begin
      st_nxt.phy_rdy = 1'b1;
    end else begin
      st_nxt.phy_cnt = st_r.phy_cnt + 18'h00001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.ring_start <= RING_START_RST;
      st_r.ring_end   <= RING_END_RST;
      st_r.wr_ptr     <= RING_START_RST;
      st_r.rd_ptr     <= RING_END_RST;
      st_r.in_ring    <= (RING_START_RST <= RING_END_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.tx_request       = st_r.tx_req;
  assign bus.tx_abort_status  = st_r.tx_abort;
  assign bus.copy_start       = st_r.copy_st;
  assign bus.tx_done_flag     = st_r.tx_done;
  assign bus.copy_done_flag   = st_r.copy_done;
  assign bus.phy_link_flag    = st_r.phy_link;
  assign bus.phy_global_flag  = st_r.phy_global;
  assign bus.link_change_flag = st_r.link_change;
  assign bus.rx_pending_flag  = st_r.rx_pend;
  assign bus.rx_packet_count  = st_r.pkt_cnt;
  assign bus.rx_ring_start    = st_r.ring_start;
  assign bus.rx_ring_end      = st_r.ring_end;
  assign bus.rx_write_ptr     = st_r.wr_ptr;
  assign bus.rx_read_ptr      = st_r.rd_ptr;
  assign bus.module_irq       = st_r.irq;
  assign bus.phy_ready        = st_r.phy_rdy;
  // Status vector address taken from the receive ring write pointer
  assign tx_status_addr  = st_r.wr_ptr;
  assign rx_addr_in_ring = st_r.in_ring;
endmodule // evt_dev

// >>> verilog/evt_fw.sv
// Firmware end: turns user commands into register strobes on the interface.
// Assumes the device end on the same clk_sys; strobes are one-cycle pulses.
`timescale 1ns/100ps
module evt_fw
  import evt_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  evt_if.fw                     bus,
  input  wire logic             cmd_tx_go,
  input  wire logic             cmd_tx_cancel,
  input  wire logic             cmd_copy_go,
  input  wire logic             cmd_copy_cancel,
  input  wire logic             cmd_clr_tx,
  input  wire logic             cmd_clr_copy,
  input  wire logic             cmd_phy_read,
  input  wire logic             cmd_pkt_done,
  input  wire logic             cmd_ring_setup,
  input  wire logic [PTR_W-1:0] ring_start_in,
  input  wire logic [PTR_W-1:0] ring_end_in,
  input  wire logic [6:0]       enables_in,
  input  wire logic [FILT_W-1:0] filter_in,
  output logic                  tx_ok,
  output logic                  setup_busy
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_END, S_RDL, S_RDH} setup_t;
  typedef struct packed {
    setup_t           ph;
    logic [PTR_W-1:0] end_hold;
    logic             tx_wait;
    logic             cancelled;
    logic             ok;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.ph)
      S_IDLE:  if (cmd_ring_setup && bus.phy_ready) begin
        st_nxt.ph       = S_START;
        st_nxt.end_hold = {ring_end_in[PTR_W-1:1], 1'b1};
      end
      S_START: st_nxt.ph = S_END;
      S_END:   st_nxt.ph = S_RDL;
      S_RDL:   st_nxt.ph = S_RDH;
      S_RDH:   st_nxt.ph = S_IDLE;
    endcase
    if (cmd_tx_go && !bus.tx_request) begin
      st_nxt.tx_wait   = 1'b1;
      st_nxt.cancelled = 1'b0;
    end
    if (cmd_tx_cancel) begin
      st_nxt.cancelled = 1'b1;
    end
    if (st_r.tx_wait && bus.tx_done_flag) begin
      st_nxt.tx_wait = 1'b0;
      st_nxt.ok      = !st_r.cancelled && !bus.tx_abort_status;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '{ph: S_IDLE, end_hold: RING_END_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.tx_request_set     = cmd_tx_go && !bus.tx_request;
  assign bus.tx_request_cancel  = cmd_tx_cancel;
  assign bus.copy_start_set     = cmd_copy_go;
  assign bus.copy_start_cancel  = cmd_copy_cancel;
  assign bus.tx_done_clr        = cmd_clr_tx | (st_r.tx_wait & bus.tx_done_flag);
  assign bus.copy_done_clr      = cmd_clr_copy;
  assign bus.phy_irq_request_rd = cmd_phy_read;
  assign bus.rx_count_dec       = cmd_pkt_done;
  // Enables order: tx, copy, link, rx pending, module, phy link, phy global
  assign bus.tx_done_irq_en     = enables_in[0];
  assign bus.copy_done_irq_en   = enables_in[1];
  assign bus.link_change_irq_en = enables_in[2];
  assign bus.rx_pending_irq_en  = enables_in[3];
  assign bus.module_irq_en      = enables_in[4];
  assign bus.phy_link_irq_en    = enables_in[5];
  assign bus.phy_global_irq_en  = enables_in[6];
  assign bus.rx_filter_ctrl     = filter_in;
  assign bus.ring_start_wr      = (st_r.ph == S_START);
  assign bus.ring_end_wr        = (st_r.ph == S_END);
  assign bus.ring_wdata         = (st_r.ph == S_START) ? {ring_start_in[PTR_W-1:1], 1'b0}
                                                       : st_r.end_hold;
  assign bus.rd_ptr_low_wr      = (st_r.ph == S_RDL);
  assign bus.rd_ptr_high_wr     = (st_r.ph == S_RDH);
  assign bus.rd_ptr_byte        = (st_r.ph == S_RDH) ? {3'b000, st_r.end_hold[PTR_W-1:8]}
                                                     : st_r.end_hold[7:0];
  assign tx_ok      = st_r.ok;
  assign setup_busy = (st_r.ph != S_IDLE);
endmodule // evt_fw

// >>> verification/evt_monitor.sv
// Checker for the signals between the device end and the firmware end.
// Assumes tb_top instantiates it beside the interface, on clk_sys.
`timescale 1ns/100ps
module evt_monitor
  import evt_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             tx_request,
  input wire logic             copy_start,
  input wire logic             tx_done_irq_en,
  input wire logic             copy_done_irq_en,
  input wire logic             link_change_irq_en,
  input wire logic             module_irq_en,
  input wire logic             phy_link_irq_en,
  input wire logic             phy_global_irq_en,
  input wire logic             tx_done_clr,
  input wire logic             copy_done_clr,
  input wire logic             tx_done_flag,
  input wire logic             link_change_flag,
  input wire logic             phy_global_flag,
  input wire logic             phy_link_flag,
  input wire logic             copy_done_flag,
  input wire logic             rx_pending_flag,
  input wire logic [CNT_W-1:0] rx_packet_count,
  input wire logic             module_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_tx_end;
    $fell(tx_request);
  endsequence
  sequence s_copy_end;
    $fell(copy_start);
  endsequence

  chk_tx_done_set: assert property (s_tx_end |-> tx_done_flag)
    else $error("tx done flag missing at request end");
  chk_tx_done_hold: assert property (tx_done_flag && !tx_done_clr |=> tx_done_flag)
    else $error("tx done flag dropped without clear");
  chk_tx_irq_raise: assert property (tx_done_flag && tx_done_irq_en && module_irq_en |=> module_irq)
    else $error("tx done irq missing");
  chk_link_gate_off: assert property (!(phy_link_irq_en && phy_global_irq_en) |=> !link_change_flag)
    else $error("link flag set with phy enables off");
  chk_link_mirror: assert property (link_change_flag |-> phy_global_flag && phy_link_flag)
    else $error("link flag differs from phy flags");
  chk_link_irq_raise: assert property (link_change_flag && link_change_irq_en && phy_link_irq_en
    && phy_global_irq_en && module_irq_en |=> module_irq)
    else $error("link irq missing");
  chk_copy_done_set: assert property (s_copy_end |-> copy_done_flag)
    else $error("copy done flag missing at copy end");
  chk_copy_done_hold: assert property (copy_done_flag && !copy_done_clr |=> copy_done_flag)
    else $error("copy done flag dropped without clear");
  chk_copy_irq_raise: assert property (copy_done_flag && copy_done_irq_en && module_irq_en
    |=> module_irq)
    else $error("copy done irq missing");
  chk_rx_pend_count: assert property (rx_pending_flag == (rx_packet_count != CNT_ZERO))
    else $error("rx pending flag differs from count");
  chk_irq_module_gate: assert property (!module_irq_en |=> !module_irq)
    else $error("irq raised with module enable off");
endmodule // evt_monitor

// >>> verification/tb_top.sv
// Testbench joining both ends through the interface, with checker beside it.
// Assumes one 200 MHz clock; inputs driven at the falling edge.
`timescale 1ns/100ps
module tb_top;
  import evt_pkg::*;
  logic              clk_sys;
  logic              sys_rst = 1'b1;
  logic [8:0]        cmd = '0;
  logic [6:0]        eng = '0;
  logic [6:0]        enables = '0;
  logic [FILT_W-1:0] filter = '0;
  logic              tx_ok;
  logic              pwr = 1'b0;
  logic              in_ring;
  logic              setup_busy;
  int                num_errors = 0;
  int                checks = 0;

  evt_if bus ();
  evt_dev evt_dev_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus.dev), .tx_end(eng[0]),
    .tx_abort(eng[1]), .copy_end(eng[2]), .link_status_change(eng[3]),
    .rx_packet_stored(eng[4]), .rx_wake_frame(eng[5]), .rx_wr_advance(eng[6]),
    .module_power_en(pwr), .tx_status_addr(), .rx_addr_in_ring(in_ring));
  evt_fw evt_fw_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus.fw), .cmd_tx_go(cmd[0]),
    .cmd_tx_cancel(cmd[1]), .cmd_copy_go(cmd[2]), .cmd_copy_cancel(cmd[3]),
    .cmd_clr_tx(cmd[4]), .cmd_clr_copy(cmd[5]), .cmd_phy_read(cmd[6]), .cmd_pkt_done(cmd[7]),
    .cmd_ring_setup(cmd[8]), .ring_start_in(13'h0000), .ring_end_in(13'h1FFF),
    .enables_in(enables), .filter_in(filter), .tx_ok(tx_ok), .setup_busy(setup_busy));
  evt_monitor evt_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tx_request(bus.tx_request),
    .copy_start(bus.copy_start), .tx_done_irq_en(bus.tx_done_irq_en),
    .copy_done_irq_en(bus.copy_done_irq_en), .link_change_irq_en(bus.link_change_irq_en),
    .module_irq_en(bus.module_irq_en), .phy_link_irq_en(bus.phy_link_irq_en),
    .phy_global_irq_en(bus.phy_global_irq_en), .tx_done_clr(bus.tx_done_clr),
    .copy_done_clr(bus.copy_done_clr), .tx_done_flag(bus.tx_done_flag),
    .link_change_flag(bus.link_change_flag), .phy_global_flag(bus.phy_global_flag),
    .phy_link_flag(bus.phy_link_flag), .copy_done_flag(bus.copy_done_flag),
    .rx_pending_flag(bus.rx_pending_flag), .rx_packet_count(bus.rx_packet_count),
    .module_irq(bus.module_irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle firmware command, then settle
  task automatic fw(input logic [8:0] m, input int n);
    cmd = m;
    @(negedge clk_sys);
    cmd = '0;
    repeat (n) @(negedge clk_sys);
  endtask

  // One-cycle engine event, then settle
  task automatic ev(input logic [6:0] m, input int n);
    eng = m;
    @(negedge clk_sys);
    eng = '0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic results();
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    results();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    pwr = 1'b1;
    chk1(bus.link_change_flag | bus.module_irq | bus.rx_pending_flag, 1'b0);
    chkn(bus.rx_read_ptr, RING_END_RST);
    chkn(bus.rx_write_ptr, RING_START_RST);
    chk1(in_ring, 1'b1);
    // Ring setup refused until the PHY reports ready
    fw(9'h100, 0);
    chk1(setup_busy | bus.phy_ready, 1'b0);
    ev(7'h40, 1);
    chkn(bus.rx_write_ptr, RING_START_RST + 13'h0001);
    chk1(in_ring, 1'b1);
    // Transmit: success, abort, cancel with its interrupt masked
    enables = 7'h11;
    fw(9'h001, 3);
    ev(7'h01, 1);
    chk1(bus.module_irq, 1'b1);
    chk1(tx_ok, 1'b1);
    chk1(bus.tx_request, 1'b0);
    fw(9'h001, 3);
    ev(7'h03, 4);
    chk1(tx_ok, 1'b0);
    chk1(bus.tx_abort_status, 1'b1);
    enables = 7'h10;
    fw(9'h001, 3);
    fw(9'h002, 1);
    chk1(bus.module_irq, 1'b0);
    chk1(tx_ok, 1'b0);
    chk1(bus.tx_request, 1'b0);
    // Copy engine: done, hold, clear, cancel, masked
    enables = 7'h12;
    fw(9'h004, 3);
    ev(7'h04, 3);
    chk1(bus.copy_done_flag, 1'b1);
    chk1(bus.module_irq, 1'b1);
    repeat (10) @(negedge clk_sys);
    chk1(bus.copy_done_flag, 1'b1);
    fw(9'h020, 3);
    chk1(bus.copy_done_flag | bus.module_irq, 1'b0);
    fw(9'h004, 3);
    fw(9'h008, 3);
    chk1(bus.copy_done_flag, 1'b1);
    enables = 7'h02;
    repeat (3) @(negedge clk_sys);
    chk1(bus.module_irq, 1'b0);
    chk1(bus.copy_done_flag, 1'b1);
    fw(9'h020, 3);
    // Receive count, pending flag, one interrupt per packet
    enables = 7'h18;
    ev(7'h10, 0);
    chk1(bus.module_irq, 1'b1);
    @(negedge clk_sys);
    ev(7'h10, 3);
    chk1(bus.module_irq, 1'b0);
    chkn(PTR_W'(bus.rx_packet_count), 13'h0002);
    fw(9'h080, 3);
    chk1(bus.rx_pending_flag, 1'b1);
    fw(9'h080, 3);
    chk1(bus.rx_pending_flag, 1'b0);
    fw(9'h080, 3);
    chkn(PTR_W'(bus.rx_packet_count), 13'h0000);
    // Wake frame counts only with both filter bits
    filter = 8'h28;
    ev(7'h20, 3);
    chkn(PTR_W'(bus.rx_packet_count), 13'h0001);
    fw(9'h080, 3);
    filter = 8'h20;
    ev(7'h20, 3);
    chkn(PTR_W'(bus.rx_packet_count), 13'h0000);
    // Link change without and with PHY enables, then PHY read
    enables = 7'h14;
    ev(7'h08, 3);
    chk1(bus.link_change_flag, 1'b0);
    chk1(bus.phy_link_flag, 1'b1);
    enables = 7'h74;
    ev(7'h08, 3);
    chk1(bus.link_change_flag, 1'b1);
    chk1(bus.phy_global_flag, 1'b1);
    chk1(bus.module_irq, 1'b1);
    fw(9'h040, 3);
    chk1(bus.link_change_flag | bus.phy_global_flag | bus.phy_link_flag, 1'b0);
    chk1(bus.module_irq, 1'b0);
    results();
  end
endmodule // tb_top
